/* File: logic/wbm_pkg.sv */
// constants for the watchdog and bus mode control registers
`default_nettype none
package wbm_pkg;
   // ---------------------------------------------------------------
   // register addresses and widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam logic [6:0] HW_ADDR = 7'h02;
   localparam logic [6:0] WD_ADDR = 7'h03;
   localparam logic [6:0] BUS_ADDR = 7'h04;
   // ---------------------------------------------------------------
   // hardware control register
   // ---------------------------------------------------------------
   localparam logic [15:0] HW_WR_MASK = 16'h1e64;
   localparam logic [15:0] HW_POR_VAL = 16'h0000;
   localparam logic [15:0] HW_SOFT_KEEP = 16'h0200;
   localparam logic [15:0] HW_RESTART_KEEP = 16'h1240;
   localparam int HW_FAIL_BIT = 5;
   localparam int HW_STM1_BIT = 2;
   // ---------------------------------------------------------------
   // watchdog control register
   // ---------------------------------------------------------------
   localparam logic [15:0] WD_WR_MASK = 16'h8077;
   localparam logic [15:0] WD_RST_VAL = 16'h0014;
   localparam logic [15:0] WD_RESTART_KEEP = 16'h0010;
   localparam logic [15:0] WD_RESTART_SET = 16'h0004;
   localparam int WD_CHK_BIT = 15;
   localparam int WD_STM0_BIT = 6;
   localparam int WD_TYPE_BIT = 5;
   localparam int WD_WAKE_BIT = 4;
   localparam int WD_PER_LSB = 0;
   localparam int WD_PER_W = 3;
   // ---------------------------------------------------------------
   // bus transceiver mode register
   // ---------------------------------------------------------------
   localparam logic [15:0] BUS_WR_MASK = 16'h00ff;
   localparam logic [15:0] BUS_RST_VAL = 16'h0000;
   localparam logic [15:0] BUS_RESTART_KEEP = 16'h00d4;
   localparam logic [15:0] BUS_FS_KEEP = 16'h00e0;
   localparam logic [15:0] BUS_FS_SET = 16'h0009;
   localparam int BUS_FLASH_BIT = 7;
   localparam int BUS_LSM_BIT = 6;
   localparam int BUS_TXTO_BIT = 5;
   localparam int BUS_LIN_LSB = 3;
   localparam int BUS_SELWAKE_BIT = 2;
   localparam int BUS_CAN_LSB = 0;
   // transceiver mode codes, shared by lin and can
   localparam logic [1:0] XCV_OFF = 2'h0;
   localparam logic [1:0] XCV_WAKE = 2'h1;
   localparam logic [1:0] XCV_RECEIVE = 2'h2;
   localparam logic [1:0] XCV_NORMAL = 2'h3;
   // ---------------------------------------------------------------
   // watchdog period in milliseconds, index is the period code
   // ---------------------------------------------------------------
   localparam int PER_MS_W = 16;
   localparam logic [15:0] PER_MS_0 = 16'h000a;
   localparam logic [15:0] PER_MS_1 = 16'h0014;
   localparam logic [15:0] PER_MS_2 = 16'h0032;
   localparam logic [15:0] PER_MS_3 = 16'h0064;
   localparam logic [15:0] PER_MS_4 = 16'h00c8;
   localparam logic [15:0] PER_MS_5 = 16'h01f4;
   localparam logic [15:0] PER_MS_6 = 16'h03e8;
   localparam logic [15:0] PER_MS_7 = 16'h2710;
endpackage
`default_nettype wire

/* File: logic/wbm_period_if.sv */
// period code to period length carrier between the register bank and the lookup
`timescale 1ns/1ns
`default_nettype none
interface wbm_period_if;
   logic [wbm_pkg::WD_PER_W-1:0] code;
   logic [wbm_pkg::PER_MS_W-1:0] ms;
   modport bank (output code, input ms);
   modport lut (input code, output ms);
endinterface
`default_nettype wire

/* File: logic/wbm_period_lut.sv */
// watchdog period code to milliseconds lookup
`timescale 1ns/1ns
`default_nettype none
module wbm_period_lut (
   wbm_period_if.lut per
);
   logic [wbm_pkg::PER_MS_W-1:0] ms_sel;

   always_comb begin
      unique case (per.code)
         3'h0: ms_sel = wbm_pkg::PER_MS_0;
         3'h1: ms_sel = wbm_pkg::PER_MS_1;
         3'h2: ms_sel = wbm_pkg::PER_MS_2;
         3'h3: ms_sel = wbm_pkg::PER_MS_3;
         3'h4: ms_sel = wbm_pkg::PER_MS_4;
         3'h5: ms_sel = wbm_pkg::PER_MS_5;
         3'h6: ms_sel = wbm_pkg::PER_MS_6;
         3'h7: ms_sel = wbm_pkg::PER_MS_7;
      endcase
   end

   assign per.ms = ms_sel;
endmodule
`default_nettype wire

/* File: logic/wbm_regs.sv */
// watchdog, bus transceiver mode and hardware control register bank
`timescale 1ns/1ns
`default_nettype none
module wbm_regs (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [wbm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [wbm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [wbm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic soft_reset_pulse,
   input wire logic restart_entry_pulse,
   input wire logic stop_to_normal_pulse,
   input wire logic failsafe_entry_pulse,
   input wire logic sleep_entry_pulse,
   input wire logic system_error_flag,
   input wire logic failure_status,
   input wire logic fail_pin_is_output,
   output logic fail_signal_pin,
   output logic [wbm_pkg::DATA_W-1:0] hw_ctrl_value,
   output logic dog_checksum_bit,
   output logic stop_dog_off_first,
   output logic stop_dog_off_second,
   output logic dog_type_select,
   output logic dog_start_on_bus_wake,
   output logic [wbm_pkg::WD_PER_W-1:0] dog_period_select,
   output logic [wbm_pkg::PER_MS_W-1:0] dog_period_ms,
   output logic lin_flash_no_slope,
   output logic lin_low_slope_select,
   output logic lin_transmit_timeout_enable,
   output logic [1:0] lin_mode,
   output logic [1:0] can_mode,
   output logic selective_wake
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [15:0] hw_ff;
   logic [15:0] wd_ff;
   logic [15:0] bus_ff;
   logic [15:0] rdata_ff;
   logic fail_pin_ff;
   logic [15:0] nxt_hw_ff;
   logic [15:0] nxt_wd_ff;
   logic [15:0] nxt_bus_ff;
   logic [15:0] nxt_rdata_ff;
   logic nxt_fail_pin_ff;

   wbm_period_if per ();

   wbm_period_lut u_lut (
      .per(per)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire sel_hw = reg_addr == wbm_pkg::HW_ADDR;
   wire sel_wd = reg_addr == wbm_pkg::WD_ADDR;
   wire sel_bus = reg_addr == wbm_pkg::BUS_ADDR;
   wire wr_hw = reg_wr_en & sel_hw;
   wire wr_wd = reg_wr_en & sel_wd;
   wire wr_bus = reg_wr_en & sel_bus;

   // reserved positions keep their zero, only masked fields move
   wire [15:0] hw_wr_val = (hw_ff & ~wbm_pkg::HW_WR_MASK) | (reg_wdata & wbm_pkg::HW_WR_MASK);
   wire [15:0] wd_wr_val = (wd_ff & ~wbm_pkg::WD_WR_MASK) | (reg_wdata & wbm_pkg::WD_WR_MASK);
   wire [15:0] bus_wr_val = (bus_ff & ~wbm_pkg::BUS_WR_MASK) | (reg_wdata & wbm_pkg::BUS_WR_MASK);

   // ---------------------------------------------------------------
   // hardware control register next value
   // ---------------------------------------------------------------
   wire [15:0] hw_after_wr = wr_hw ? hw_wr_val : hw_ff;
   wire [15:0] hw_stm1_clr = ~(16'h0001 << wbm_pkg::HW_STM1_BIT);
   wire [15:0] hw_after_mode = stop_to_normal_pulse ? (hw_after_wr & hw_stm1_clr) : hw_after_wr;
   // restart drops the software fail assert bit with everything not kept
   wire [15:0] hw_restart_val = hw_ff & wbm_pkg::HW_RESTART_KEEP;
   wire [15:0] hw_soft_val = hw_ff & wbm_pkg::HW_SOFT_KEEP;

   assign nxt_hw_ff = restart_entry_pulse ? hw_restart_val :
                      soft_reset_pulse ? hw_soft_val : hw_after_mode;

   // ---------------------------------------------------------------
   // watchdog control register next value
   // ---------------------------------------------------------------
   wire [15:0] wd_restart_val = (wd_ff & wbm_pkg::WD_RESTART_KEEP) | wbm_pkg::WD_RESTART_SET;

   assign nxt_wd_ff = soft_reset_pulse ? wbm_pkg::WD_RST_VAL :
                      restart_entry_pulse ? wd_restart_val :
                      wr_wd ? wd_wr_val : wd_ff;

   // ---------------------------------------------------------------
   // bus transceiver mode register next value
   // ---------------------------------------------------------------
   wire [1:0] can_low = bus_ff[wbm_pkg::BUS_CAN_LSB +: 2];
   // receive only also drops to wake capable on sleep, unlike stop
   wire sleep_to_wake = sleep_entry_pulse & ~system_error_flag &
                        ((can_low == wbm_pkg::XCV_NORMAL) | (can_low == wbm_pkg::XCV_RECEIVE));
   wire [15:0] bus_sleep_val = (bus_ff & ~(16'h0003 << wbm_pkg::BUS_CAN_LSB)) |
                               (16'(wbm_pkg::XCV_WAKE) << wbm_pkg::BUS_CAN_LSB);
   wire [15:0] bus_fs_val = (bus_ff & wbm_pkg::BUS_FS_KEEP) | wbm_pkg::BUS_FS_SET;
   wire [15:0] bus_restart_val = bus_ff & wbm_pkg::BUS_RESTART_KEEP;

   // device driven changes win over a write in the same cycle
   assign nxt_bus_ff = soft_reset_pulse ? wbm_pkg::BUS_RST_VAL :
                       restart_entry_pulse ? bus_restart_val :
                       failsafe_entry_pulse ? bus_fs_val :
                       sleep_to_wake ? bus_sleep_val :
                       wr_bus ? bus_wr_val : bus_ff;

   // ---------------------------------------------------------------
   // fail pin and read data
   // ---------------------------------------------------------------
   // failure keeps the pin up even after software drops its own request
   assign nxt_fail_pin_ff = fail_pin_is_output & (nxt_hw_ff[wbm_pkg::HW_FAIL_BIT] | failure_status);

   wire [15:0] rd_mux = sel_hw ? hw_ff :
                        sel_wd ? wd_ff :
                        sel_bus ? bus_ff : 16'h0000;
   assign nxt_rdata_ff = reg_rd_en ? rd_mux : rdata_ff;

   // ---------------------------------------------------------------
   // flip-flops
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!resetn) begin
         hw_ff <= wbm_pkg::HW_POR_VAL;
         wd_ff <= wbm_pkg::WD_RST_VAL;
         bus_ff <= wbm_pkg::BUS_RST_VAL;
         rdata_ff <= 16'h0000;
         fail_pin_ff <= 1'b0;
      end else begin
         hw_ff <= nxt_hw_ff;
         wd_ff <= nxt_wd_ff;
         bus_ff <= nxt_bus_ff;
         rdata_ff <= nxt_rdata_ff;
         fail_pin_ff <= nxt_fail_pin_ff;
      end
   end

   // ---------------------------------------------------------------
   // field outputs
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_ff;
   assign fail_signal_pin = fail_pin_ff;
   assign hw_ctrl_value = hw_ff;
   assign stop_dog_off_second = hw_ff[wbm_pkg::HW_STM1_BIT];
   assign dog_checksum_bit = wd_ff[wbm_pkg::WD_CHK_BIT];
   assign stop_dog_off_first = wd_ff[wbm_pkg::WD_STM0_BIT];
   assign dog_type_select = wd_ff[wbm_pkg::WD_TYPE_BIT];
   assign dog_start_on_bus_wake = wd_ff[wbm_pkg::WD_WAKE_BIT];
   assign dog_period_select = wd_ff[wbm_pkg::WD_PER_LSB +: wbm_pkg::WD_PER_W];
   assign per.code = dog_period_select;
   assign dog_period_ms = per.ms;
   assign lin_flash_no_slope = bus_ff[wbm_pkg::BUS_FLASH_BIT];
   assign lin_low_slope_select = bus_ff[wbm_pkg::BUS_LSM_BIT];
   assign lin_transmit_timeout_enable = bus_ff[wbm_pkg::BUS_TXTO_BIT];
   assign lin_mode = bus_ff[wbm_pkg::BUS_LIN_LSB +: 2];
   assign can_mode = bus_ff[wbm_pkg::BUS_CAN_LSB +: 2];
   assign selective_wake = bus_ff[wbm_pkg::BUS_SELWAKE_BIT];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   wire quiet = ~soft_reset_pulse & ~restart_entry_pulse;
   // a bus write that no device event overrides
   wire bus_wr_only = wr_bus & quiet & ~failsafe_entry_pulse & ~sleep_to_wake;

   fail_pin_hold_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (failure_status & fail_pin_is_output) |=> fail_signal_pin)
      else $error("fail pin dropped while failure active");

   fail_restart_clear_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (restart_entry_pulse & ~failure_status & fail_pin_is_output) |=> !fail_signal_pin)
      else $error("fail pin not released after restart");

   stop_bit_clear_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (stop_to_normal_pulse & ~soft_reset_pulse) |=> !stop_dog_off_second)
      else $error("second stop bit survived stop to normal");

   hw_restart_keep_a:
   assert property (@(posedge clock) disable iff (!resetn)
      restart_entry_pulse |=> hw_ff == ($past(hw_ff) & wbm_pkg::HW_RESTART_KEEP))
      else $error("hardware control restart value wrong");

   hw_soft_keep_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (soft_reset_pulse & ~restart_entry_pulse) |=> hw_ff == ($past(hw_ff) & wbm_pkg::HW_SOFT_KEEP))
      else $error("hardware control soft reset value wrong");

   reserved_zero_a:
   assert property (@(posedge clock) disable iff (!resetn)
      ((wd_ff & ~wbm_pkg::WD_WR_MASK) == 16'h0000) && ((bus_ff & ~wbm_pkg::BUS_WR_MASK) == 16'h0000))
      else $error("reserved bit set");

   period_map_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h7) |-> (dog_period_ms == wbm_pkg::PER_MS_7))
      else $error("period lookup wrong");

   wd_soft_load_a:
   assert property (@(posedge clock) disable iff (!resetn)
      soft_reset_pulse |=> wd_ff == wbm_pkg::WD_RST_VAL)
      else $error("watchdog soft reset value wrong");

   wd_restart_val_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (restart_entry_pulse & ~soft_reset_pulse) |=>
         (dog_period_select == 3'h4) && !dog_type_select && !stop_dog_off_first &&
         (dog_start_on_bus_wake == $past(dog_start_on_bus_wake)))
      else $error("watchdog restart value wrong");

   bus_failsafe_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (failsafe_entry_pulse & quiet) |=> (can_mode == wbm_pkg::XCV_WAKE) &&
         (lin_mode == wbm_pkg::XCV_WAKE) && !selective_wake)
      else $error("fail safe did not force wake capable");

   can_sleep_wake_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (sleep_entry_pulse & ~system_error_flag & ~failsafe_entry_pulse & quiet &
         (can_mode == wbm_pkg::XCV_NORMAL)) |=> can_mode == wbm_pkg::XCV_WAKE)
      else $error("can not set wake capable on sleep");

   wd_write_mask_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> wd_ff == ($past(reg_wdata) & wbm_pkg::WD_WR_MASK))
      else $error("watchdog write not masked");

   chk_bit_store_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> dog_checksum_bit == $past(reg_wdata[wbm_pkg::WD_CHK_BIT]))
      else $error("checksum bit not stored");

   stop_first_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> stop_dog_off_first == $past(reg_wdata[wbm_pkg::WD_STM0_BIT]))
      else $error("first stop bit not stored");

   dog_type_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> dog_type_select == $past(reg_wdata[wbm_pkg::WD_TYPE_BIT]))
      else $error("watchdog type not stored");

   bus_wake_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> dog_start_on_bus_wake == $past(reg_wdata[wbm_pkg::WD_WAKE_BIT]))
      else $error("bus wake enable not stored");

   period_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_wd & quiet) |=> dog_period_select == $past(reg_wdata[wbm_pkg::WD_PER_LSB +: wbm_pkg::WD_PER_W]))
      else $error("period code not stored");

   period_zero_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h0) |-> (dog_period_ms == wbm_pkg::PER_MS_0))
      else $error("period lookup wrong");

   period_one_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h1) |-> (dog_period_ms == wbm_pkg::PER_MS_1))
      else $error("period lookup wrong");

   period_two_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h2) |-> (dog_period_ms == wbm_pkg::PER_MS_2))
      else $error("period lookup wrong");

   period_three_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h3) |-> (dog_period_ms == wbm_pkg::PER_MS_3))
      else $error("period lookup wrong");

   period_four_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h4) |-> (dog_period_ms == wbm_pkg::PER_MS_4))
      else $error("period lookup wrong");

   period_five_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h5) |-> (dog_period_ms == wbm_pkg::PER_MS_5))
      else $error("period lookup wrong");

   period_six_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (dog_period_select == 3'h6) |-> (dog_period_ms == wbm_pkg::PER_MS_6))
      else $error("period lookup wrong");

   lin_flash_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> lin_flash_no_slope == $past(reg_wdata[wbm_pkg::BUS_FLASH_BIT]))
      else $error("lin flash bit not stored");

   lin_slope_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> lin_low_slope_select == $past(reg_wdata[wbm_pkg::BUS_LSM_BIT]))
      else $error("lin slope bit not stored");

   lin_timeout_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> lin_transmit_timeout_enable == $past(reg_wdata[wbm_pkg::BUS_TXTO_BIT]))
      else $error("lin timeout bit not stored");

   lin_mode_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> lin_mode == $past(reg_wdata[wbm_pkg::BUS_LIN_LSB +: 2]))
      else $error("lin mode not stored");

   can_mode_write_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> {selective_wake, can_mode} == $past(reg_wdata[wbm_pkg::BUS_CAN_LSB +: 3]))
      else $error("can mode not stored");

   bus_write_mask_a:
   assert property (@(posedge clock) disable iff (!resetn)
      bus_wr_only |=> bus_ff == ($past(reg_wdata) & wbm_pkg::BUS_WR_MASK))
      else $error("bus write not masked");

   hw_write_mask_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (wr_hw & quiet & ~stop_to_normal_pulse) |=> hw_ctrl_value == ($past(reg_wdata) & wbm_pkg::HW_WR_MASK))
      else $error("hardware control write not masked");

   hw_reserved_zero_a:
   assert property (@(posedge clock) disable iff (!resetn)
      (hw_ff & ~wbm_pkg::HW_WR_MASK) == 16'h0000)
      else $error("hardware control reserved bit set");

   fail_sw_clear_a:
   assert property (@(posedge clock) disable iff (!resetn)
      restart_entry_pulse |=> !hw_ctrl_value[wbm_pkg::HW_FAIL_BIT])
      else $error("software fail assert survived restart");
endmodule
`default_nettype wire

/* File: testbench/wbm_host_model.sv */
// host side model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module wbm_host_model (
   input wire logic clock,
   output logic [wbm_pkg::ADDR_W-1:0] reg_addr,
   output logic [wbm_pkg::DATA_W-1:0] reg_wdata,
   output logic reg_wr_en,
   output logic reg_rd_en,
   input wire logic [wbm_pkg::DATA_W-1:0] reg_rdata
);
   initial begin
      reg_addr = 7'h7f;
      reg_wdata = 16'h0000;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
   end
   // -------------------------------------------------------------
   // bus cycles
   // -------------------------------------------------------------
   // released lines flip so a stale value never passes for a held one
   task automatic release_bus();
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
   endtask
   // caller supplies the checksum bit in bit 15 itself
   task automatic write_reg(input logic [6:0] addr, input logic [15:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr_en <= 1'b1;
      @(posedge clock);
      release_bus();
      #1;
   endtask
   task automatic read_reg(input logic [6:0] addr, output logic [15:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_rd_en <= 1'b1;
      @(posedge clock);
      release_bus();
      #1;
      data = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* File: testbench/watchdog_bus_mode_ctrl_regs_tb.sv */
// self-checking bench for the watchdog and bus mode register bank
`timescale 1ns/1ns
`default_nettype none
module watchdog_bus_mode_ctrl_regs_tb;
   typedef struct packed {
      logic [6:0] addr;
      logic [15:0] wdata;
      logic [15:0] exp;
   } wbm_row_t;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] events = 5'h00;
   logic system_error_flag = 1'b0;
   logic failure_status = 1'b0;
   logic fail_pin_is_output = 1'b1;
   logic [6:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, hw_ctrl_value, rd;
   logic reg_wr_en, reg_rd_en, fail_signal_pin, dog_checksum_bit, stop_dog_off_first, stop_dog_off_second;
   logic dog_type_select, dog_start_on_bus_wake, lin_flash_no_slope, lin_low_slope_select;
   logic lin_transmit_timeout_enable, selective_wake;
   logic [2:0] dog_period_select;
   logic [15:0] dog_period_ms;
   logic [1:0] lin_mode, can_mode;
   int failures = 0;
   int compares = 0;
   wbm_row_t rows[7] = '{
      '{7'h03, 16'hffff, 16'h8077}, '{7'h03, 16'h0000, 16'h0000}, '{7'h03, 16'h0023, 16'h0023},
      '{7'h04, 16'hffff, 16'h00ff}, '{7'h04, 16'h0055, 16'h0055}, '{7'h04, 16'h00aa, 16'h00aa},
      '{7'h05, 16'hffff, 16'h0000}};
   logic [15:0] ms_tab[8] = '{16'h000a, 16'h0014, 16'h0032, 16'h0064, 16'h00c8, 16'h01f4, 16'h03e8, 16'h2710};
   always #50 clock = ~clock;
   wbm_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));
   wbm_regs dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .soft_reset_pulse(events[0]),
      .restart_entry_pulse(events[1]), .stop_to_normal_pulse(events[2]), .failsafe_entry_pulse(events[3]),
      .sleep_entry_pulse(events[4]), .system_error_flag(system_error_flag), .failure_status(failure_status),
      .fail_pin_is_output(fail_pin_is_output), .fail_signal_pin(fail_signal_pin), .hw_ctrl_value(hw_ctrl_value),
      .dog_checksum_bit(dog_checksum_bit), .stop_dog_off_first(stop_dog_off_first),
      .stop_dog_off_second(stop_dog_off_second), .dog_type_select(dog_type_select),
      .dog_start_on_bus_wake(dog_start_on_bus_wake), .dog_period_select(dog_period_select),
      .dog_period_ms(dog_period_ms), .lin_flash_no_slope(lin_flash_no_slope),
      .lin_low_slope_select(lin_low_slope_select), .lin_transmit_timeout_enable(lin_transmit_timeout_enable),
      .lin_mode(lin_mode), .can_mode(can_mode), .selective_wake(selective_wake));
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic final_report();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // bit 0 soft reset, 1 restart, 2 stop to normal, 3 fail-safe, 4 sleep
   task automatic fire(input int idx);
      @(posedge clock);
      events[idx] <= 1'b1;
      @(posedge clock);
      events <= 5'h00;
      #1;
   endtask
   task automatic settle();
      @(posedge clock);
      #1;
   endtask
   task automatic expect_reg(input logic [6:0] addr, input logic [15:0] exp, input string what);
      host.read_reg(addr, rd);
      check(rd, exp, what);
   endtask
   function automatic logic [15:0] fields(input logic [6:0] addr);
      if (addr == 7'h03) begin
         return {dog_checksum_bit, 8'h00, stop_dog_off_first, dog_type_select, dog_start_on_bus_wake, 1'b0,
            dog_period_select};
      end
      if (addr == 7'h04) begin
         return {8'h00, lin_flash_no_slope, lin_low_slope_select, lin_transmit_timeout_enable, lin_mode,
            selective_wake, can_mode};
      end
      return 16'h0000;
   endfunction
   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      // far beyond the roughly 170 cycles the sequence needs
      repeat (5000) @(posedge clock);
      failures++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      expect_reg(7'h03, 16'h0014, "wd after reset");
      expect_reg(7'h04, 16'h0000, "bus after reset");
      expect_reg(7'h02, 16'h0000, "hw after reset");
      foreach (rows[i]) begin
         host.write_reg(rows[i].addr, rows[i].wdata);
         check(fields(rows[i].addr), rows[i].exp, "field outputs");
         expect_reg(rows[i].addr, rows[i].exp, "readback");
      end
      for (int i = 0; i < 8; i++) begin
         host.write_reg(7'h03, {13'h0000, 3'(i)});
         check(dog_period_ms, ms_tab[i], "period length");
      end
      host.write_reg(7'h02, 16'h1e64);
      host.write_reg(7'h03, 16'hffff);
      host.write_reg(7'h04, 16'hffff);
      fire(0);
      expect_reg(7'h02, 16'h0200, "hw soft reset");
      expect_reg(7'h03, 16'h0014, "wd soft reset");
      expect_reg(7'h04, 16'h0000, "bus soft reset");
      host.write_reg(7'h02, 16'h1e64);
      host.write_reg(7'h03, 16'hffff);
      host.write_reg(7'h04, 16'hffff);
      check({15'h0000, fail_signal_pin}, 16'h0001, "pin by software");
      fire(1);
      settle();
      check({15'h0000, fail_signal_pin}, 16'h0000, "pin after restart");
      expect_reg(7'h02, 16'h1240, "hw restart");
      expect_reg(7'h03, 16'h0014, "wd restart wake set");
      expect_reg(7'h04, 16'h00d4, "bus restart");
      host.write_reg(7'h03, 16'h8063);
      fire(1);
      expect_reg(7'h03, 16'h0004, "wd restart wake clear");
      @(posedge clock);
      failure_status <= 1'b1;
      host.write_reg(7'h02, 16'h0020);
      host.write_reg(7'h02, 16'h0000);
      settle();
      check({15'h0000, fail_signal_pin}, 16'h0001, "pin held by failure");
      host.write_reg(7'h02, 16'h0020);
      fire(1);
      settle();
      check({14'h0000, hw_ctrl_value[5], fail_signal_pin}, 16'h0001, "restart under failure");
      @(posedge clock);
      failure_status <= 1'b0;
      settle();
      settle();
      check({15'h0000, fail_signal_pin}, 16'h0000, "pin released");
      host.write_reg(7'h02, 16'h0004);
      check({15'h0000, stop_dog_off_second}, 16'h0001, "second stop bit set");
      fire(2);
      check(hw_ctrl_value, 16'h0000, "stop to normal");
      host.write_reg(7'h04, 16'h00ff);
      fire(3);
      expect_reg(7'h04, 16'h00e9, "fail-safe entry");
      host.write_reg(7'h04, 16'h0007);
      fire(4);
      expect_reg(7'h04, 16'h0005, "sleep from normal");
      @(posedge clock);
      system_error_flag <= 1'b1;
      host.write_reg(7'h04, 16'h0007);
      fire(4);
      expect_reg(7'h04, 16'h0007, "sleep with system error");
      @(posedge clock);
      system_error_flag <= 1'b0;
      host.write_reg(7'h04, 16'h0006);
      fire(4);
      expect_reg(7'h04, 16'h0005, "sleep from receive only");
      host.write_reg(7'h02, 16'h1e64);
      @(posedge clock);
      fail_pin_is_output <= 1'b0;
      settle();
      check({15'h0000, fail_signal_pin}, 16'h0000, "pin not an output");
      @(posedge clock);
      resetn <= 1'b0;
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      expect_reg(7'h02, 16'h0000, "hw power on");
      expect_reg(7'h03, 16'h0014, "wd power on");
      final_report();
   end
endmodule
`default_nettype wire
